// File: design/sync_serial_pkg.sv
// Package: register map, field layout and codes of the synchronous serial port
package sync_serial_pkg;
  // Register byte addresses
  localparam logic [7:0] TXC_ADDR = 8'h00;
  localparam logic [7:0] RSC_ADDR = 8'h04;
  localparam logic [7:0] BDC_ADDR = 8'h08;
  localparam logic [7:0] DVL_ADDR = 8'h0C;
  localparam logic [7:0] DVH_ADDR = 8'h10;
  localparam logic [7:0] TXH_ADDR = 8'h14;
  localparam logic [7:0] RXD_ADDR = 8'h18;
  localparam logic [7:0] STS_ADDR = 8'h1C;
  // transmit_status_control fields
  localparam int TXC_MASTER = 7;
  localparam int TXC_NINE = 6;
  localparam int TXC_TRANSMIT_ENABLE_BIT = 5;
  localparam int TXC_SYNC = 4;
  localparam int TXC_T9 = 0;
  localparam logic [7:0] TXC_WMASK = 8'hF5;
  // receive_status_control fields
  localparam int RSC_EN = 7;
  localparam int RSC_NINE = 6;
  localparam int RSC_SINGLE = 5;
  localparam int RSC_CONT = 4;
  localparam logic [7:0] RSC_WMASK = 8'hF0;
  // baud_control fields
  localparam int BDC_POL = 4;
  localparam int BDC_WAKE = 1;
  localparam logic [7:0] BDC_WMASK = 8'h1B;
  // Own status register fields
  localparam int STS_TXE = 0;
  localparam int STS_RXP = 1;
  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;
  // Character and sampling counts
  localparam logic [3:0] LAST8 = 4'h7;
  localparam logic [3:0] LAST9 = 4'h8;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [1:0] RXQ_FULL = 2'h2;
  localparam int RXQ_DEPTH = 2;
  // Master clock phase and asynchronous receive states
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_LEAD = 2'b01, S_TRAIL = 2'b10} sync_state_type;
  typedef enum logic [1:0] {A_IDLE = 2'b00, A_START = 2'b01, A_DATA = 2'b10, A_STOP = 2'b11} async_state_type;
endpackage

// File: design/sync_serial_port.sv
// Synchronous serial port with break receive, behind an APB register slave
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - Async break gives pending flag, framing error and data zero together.
// R2 - Wake-on-edge watches two line transitions, flags, then receives next byte.
// R3 - Clocked, master source and enable select master; rx enables pick receive.
// R4 - Master drives the clock pin and enables its driver.
// R5 - Master makes one clock per data bit, none extra.
// R6 - Polarity one idles clock high; zero idles low.
// R7 - Holding data waits for the shift register to empty, then shifts at once.
// R8 - Master transmit changes data on leading edges, holds until next.
// R9 - Master receive releases the data pin driver.
// R10 - Single receive takes one character then clears itself.
// R11 - Continuous receive clocks until cleared; clearing aborts the character.
// R12 - Both enables set: single clears after first, continuous carries on.
// R13 - Receive samples data on each trailing edge into the shift register.
// R14 - Complete characters enter a two-entry queue; pending while unread.
// R15 - Slave takes the clock from the pin and never drives it.
// R16 - A remote master gives only as many clocks as data bits.
// R17 - Third character with two unread flags overrun, keeps queue, stops.
// R18 - Single overrun clears on data read; continuous on enable clear.
// R19 - Nine-bit receive shifts nine bits; ninth bit shown in status.
// R20 - Software reads the ninth bit before the low eight bits.
// R21 - Software sets up enables and ninth bit before writing data.
// R22 - Software sets wake or auto-baud options before sleeping.
// R23 - Reading receive data pops the oldest queued character.
module sync_serial_port
  import sync_serial_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output var logic [31:0] o_prdata,
  output var logic o_pready,
  output var logic o_pslverr,
  // Shift clock pin
  input wire logic i_sck,
  output var logic o_sck,
  output var logic o_sck_oe_n,
  // Serial data pin
  input wire logic i_sdat,
  output var logic o_sdat,
  output var logic o_sdat_oe_n
);
  logic [7:0] txc_r, rsc_r, bdc_r, dvl_r, dvh_r, hold_r, rd_val;
  logic hold_full_r, sh_busy_r, ovr_r, osg_r, wake_r, wfall_r, hit;
  logic sck_m_r, sck_s_r, sck_d_r, sd_m_r, sd_s_r, sd_d_r, a_hi_r;
  logic [15:0] brg_r;
  logic [3:0] bit_r, ov_r, abit_r;
  logic [8:0] tsh_r, rsh_r, ash_r;
  logic [1:0] cnt_r;
  logic rd_ptr_r;
  logic [9:0] q_r [RXQ_DEPTH];
  sync_state_type st_r;
  async_state_type a_st_r;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  // Pin synchronisers; the third stage only feeds edge detection
  // Reset to the pulled-up idle level so no false clock edge follows reset
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sck_m_r <= 1'b1;
      sck_s_r <= 1'b1;
      sck_d_r <= 1'b1;
      sd_m_r <= 1'b1;
      sd_s_r <= 1'b1;
      sd_d_r <= 1'b1;
    end else begin
      sck_m_r <= i_sck;
      sck_s_r <= sck_m_r;
      sck_d_r <= sck_s_r;
      sd_m_r <= i_sdat;
      sd_s_r <= sd_m_r;
      sd_d_r <= sd_s_r;
    end
  end

  // Mode decode
  wire port_enable = rsc_r[RSC_EN];
  wire single_receive_enable = rsc_r[RSC_SINGLE];
  wire continuous_receive_enable = rsc_r[RSC_CONT];
  wire rxen = single_receive_enable | continuous_receive_enable;
  wire pol = bdc_r[BDC_POL];
  wire wake_on_edge_enable = bdc_r[BDC_WAKE];
  wire nine_rx = rsc_r[RSC_NINE];
  // R3 master mode select
  wire m_mode = port_enable & txc_r[TXC_SYNC] & txc_r[TXC_MASTER];
  wire s_mode = port_enable & txc_r[TXC_SYNC] & ~txc_r[TXC_MASTER];
  wire a_mode = port_enable & ~txc_r[TXC_SYNC];
  // R3 transmit when no receive enable
  wire tx_mode = port_enable & txc_r[TXC_SYNC] & txc_r[TXC_TRANSMIT_ENABLE_BIT] & ~rxen;
  // R17 overrun stops further reception
  wire m_rx_act = m_mode & rxen & ~ovr_r;
  wire s_rx_act = s_mode & continuous_receive_enable & ~ovr_r;
  wire rx_act = m_rx_act | s_rx_act;
  wire act = sh_busy_r | rx_act;

  // Bit-rate divider; the enable pulse paces both master clock and async sampling
  wire tick = (brg_r == {dvh_r, dvl_r});
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      brg_r <= 16'h0000;
    end else if (!port_enable || tick) begin
      brg_r <= 16'h0000;
    end else begin
      brg_r <= brg_r + 16'h0001;
    end
  end

  // R15 slave edges found from the sampled clock pin
  wire s_lead = (sck_s_r != sck_d_r) && (sck_s_r != pol);
  wire s_trail = (sck_s_r != sck_d_r) && (sck_s_r == pol);
  wire lead_ev = m_mode ? (st_r == S_LEAD) && tick : s_mode && s_lead;
  wire trail_ev = m_mode ? (st_r == S_TRAIL) && tick : s_mode && s_trail;
  wire [3:0] rx_last = nine_rx ? LAST9 : LAST8;
  wire [3:0] tx_last = txc_r[TXC_NINE] ? LAST9 : LAST8;
  wire [3:0] s_last = sh_busy_r ? tx_last : rx_last;
  wire s_done = trail_ev && act && (bit_r == s_last);
  wire s_rx_done = s_done && !sh_busy_r;

  // R5 master clock phases, one leading and one trailing per bit
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= S_IDLE;
    end else if (!m_mode) begin
      st_r <= S_IDLE;
    end else begin
      case (st_r)
        S_IDLE: begin
          if (act) st_r <= S_LEAD;
        end
        S_LEAD: begin
          // R11 abort at once on enable clear
          if (!act) st_r <= S_IDLE;
          else if (tick) st_r <= S_TRAIL;
        end
        S_TRAIL: begin
          if (!act) st_r <= S_IDLE;
          else if (tick) st_r <= s_done ? S_IDLE : S_LEAD;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // R6 clock sits at polarity level except between leading and trailing edges
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sck <= 1'b0;
    end else if (m_mode && act && (st_r == S_LEAD) && tick) begin
      o_sck <= ~pol;
    end else if (m_mode && act && (st_r == S_TRAIL) && !tick) begin
      o_sck <= ~pol;
    end else begin
      o_sck <= pol;
    end
  end

  // R4 clock driver on in master, R15 off in slave
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sck_oe_n <= 1'b1;
      o_sdat_oe_n <= 1'b1;
    end else begin
      o_sck_oe_n <= ~m_mode;
      // R9 data driver only while transmitting
      o_sdat_oe_n <= ~tx_mode;
    end
  end

  sck_oe_a: assert property (m_mode [*2] |-> !o_sck_oe_n) else $error("clock driver off in master"); // R4
  slv_oe_a: assert property (s_mode [*2] |-> o_sck_oe_n) else $error("clock driven in slave"); // R15
  rx_oe_a: assert property ((m_mode && rxen) [*2] |-> o_sdat_oe_n) else $error("data driven in receive"); // R9
  pol_idle_a: assert property ((m_mode && st_r == S_IDLE && $stable(pol)) [*2] |-> o_sck == pol)
    else $error("clock not at idle level"); // R6

  // Transmit shift register
  wire tx_load = tx_mode && !sh_busy_r && hold_full_r;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tsh_r <= 9'h000;
      sh_busy_r <= 1'b0;
      o_sdat <= 1'b0;
    end else if (!tx_mode) begin
      sh_busy_r <= 1'b0;
    end else if (tx_load) begin
      // R7 R21 move held byte and ninth bit in as soon as the shifter is free
      tsh_r <= {txc_r[TXC_T9], hold_r};
      sh_busy_r <= 1'b1;
    end else if (sh_busy_r) begin
      // R8 new bit only on a leading edge
      if (lead_ev) begin
        o_sdat <= tsh_r[0];
        tsh_r <= {1'b0, tsh_r[8:1]};
      end
      if (s_done) sh_busy_r <= 1'b0;
    end
  end

  hold_wait_a: assert property (sh_busy_r && hold_full_r && tx_mode |=> hold_full_r)
    else $error("held byte taken while shifting"); // R7
  data_hold_a: assert property (sh_busy_r && !lead_ev && tx_mode |=> $stable(o_sdat))
    else $error("data changed off a leading edge"); // R8

  // Bit counter, cleared whenever nothing is being moved
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bit_r <= 4'h0;
    end else if (!act || s_done) begin
      // R11 partial character dropped
      bit_r <= 4'h0;
    end else if (trail_ev) begin
      bit_r <= bit_r + 4'h1;
    end
  end

  // R13 sample data on trailing edges
  wire [8:0] rsh_nxt = {sd_s_r, rsh_r[8:1]};
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rsh_r <= 9'h000;
    end else if (trail_ev && rx_act && !sh_busy_r) begin
      rsh_r <= rsh_nxt;
    end
  end
  // R19 nine or eight bits, right aligned
  wire [8:0] s_char = nine_rx ? rsh_nxt : {1'b0, rsh_nxt[8:1]};

  abort_a: assert property (m_mode && st_r != S_IDLE && !sh_busy_r && !rxen |=> st_r == S_IDLE && o_sck == pol)
    else $error("clock not stopped on abort"); // R11

  // Asynchronous receiver, sixteen enable pulses per bit, sampled mid-bit
  wire a_run = a_mode && continuous_receive_enable && !wake_on_edge_enable;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      a_st_r <= A_IDLE;
      ov_r <= 4'h0;
      abit_r <= 4'h0;
      ash_r <= 9'h000;
      a_hi_r <= 1'b0;
    end else if (!a_run) begin
      a_st_r <= A_IDLE;
      a_hi_r <= 1'b0;
    end else if (tick) begin
      a_hi_r <= sd_s_r;
      ov_r <= ov_r + 4'h1;
      case (a_st_r)
        A_IDLE: begin
          // A held-low break must go high before another start
          ov_r <= 4'h0;
          abit_r <= 4'h0;
          if (!sd_s_r && a_hi_r) a_st_r <= A_START;
        end
        A_START: begin
          if (ov_r == OVS_MID) begin
            ov_r <= 4'h0;
            a_st_r <= sd_s_r ? A_IDLE : A_DATA;
          end
        end
        A_DATA: begin
          if (ov_r == OVS_LAST) begin
            ash_r <= {sd_s_r, ash_r[8:1]};
            abit_r <= abit_r + 4'h1;
            if (abit_r == rx_last) a_st_r <= A_STOP;
          end
        end
        A_STOP: begin
          if (ov_r == OVS_LAST) a_st_r <= A_IDLE;
        end
        default: a_st_r <= A_IDLE;
      endcase
    end
  end
  wire a_done = a_run && tick && (a_st_r == A_STOP) && (ov_r == OVS_LAST);
  wire [8:0] a_char = nine_rx ? ash_r : {1'b0, ash_r[8:1]};

  // APB decode
  wire setup = i_psel && !i_penable;
  wire acc = i_psel && i_penable && o_pready;
  wire wr = acc && i_pwrite;
  wire rd_rxd = acc && !i_pwrite && (i_paddr == RXD_ADDR);

  // Receive queue
  // R1 break stores zero data with the framing bit
  wire push_req = s_rx_done || a_done;
  wire [9:0] push_val = a_done ? {~sd_s_r, a_char} : {1'b0, s_char};
  wire pop = rd_rxd && (cnt_r != 2'h0);
  wire full = (cnt_r == RXQ_FULL) && !pop;
  // R17 no overwrite once full
  wire push_ok = push_req && !ovr_r && !full;
  wire ovr_set = push_req && !ovr_r && full;
  wire wr_idx = rd_ptr_r ^ cnt_r[0];
  wire [9:0] top = (cnt_r != 2'h0) ? q_r[rd_ptr_r] : 10'h000;
  // R14 pending while anything unread
  wire rx_pend = (cnt_r != 2'h0) || wake_r;

  // R14 queue storage
  generate
    for (genvar gi = 0; gi < RXQ_DEPTH; gi++) begin : g_q
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          q_r[gi] <= 10'h000;
        end else if (push_ok && (wr_idx == 1'(gi))) begin
          q_r[gi] <= push_val;
        end
      end
    end
  endgenerate

  // R23 read pops the oldest entry
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r <= 2'h0;
      rd_ptr_r <= 1'b0;
    end else if (!port_enable) begin
      cnt_r <= 2'h0;
      rd_ptr_r <= 1'b0;
    end else begin
      if (pop) rd_ptr_r <= ~rd_ptr_r;
      if (push_ok && !pop) cnt_r <= cnt_r + 2'h1;
      else if (pop && !push_ok) cnt_r <= cnt_r - 2'h1;
    end
  end

  // R18 overrun kind remembered so the right event clears it; set wins
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ovr_r <= 1'b0;
      osg_r <= 1'b0;
    end else if (!port_enable) begin
      ovr_r <= 1'b0;
      osg_r <= 1'b0;
    end else if (ovr_set) begin
      ovr_r <= 1'b1;
      osg_r <= single_receive_enable && !continuous_receive_enable;
    end else if (ovr_r && (osg_r ? rd_rxd : !continuous_receive_enable)) begin
      ovr_r <= 1'b0;
    end
  end

  ovr_keep_a: assert property (ovr_set |=> ovr_r && cnt_r == RXQ_FULL && $stable(q_r[0]) && $stable(q_r[1]))
    else $error("overrun lost or queue changed"); // R17
  ovr_clr_a: assert property (ovr_r && osg_r && rd_rxd && !ovr_set && port_enable |=> !ovr_r)
    else $error("single overrun kept after read"); // R18
  pend_a: assert property (push_ok && !pop |=> rx_pend && cnt_r != 2'h0)
    else $error("pending not raised on character"); // R14

  // R2 wake-on-edge: fall flags, following rise ends the wake
  wire sd_fall = sd_d_r && !sd_s_r;
  wire sd_rise = !sd_d_r && sd_s_r;
  wire wue_clr = a_mode && wake_on_edge_enable && wfall_r && sd_rise;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_r <= 1'b0;
      wfall_r <= 1'b0;
    end else if (!port_enable) begin
      wake_r <= 1'b0;
      wfall_r <= 1'b0;
    end else begin
      if (a_mode && wake_on_edge_enable && sd_fall) wake_r <= 1'b1;
      else if (rd_rxd) wake_r <= 1'b0;
      if (a_mode && wake_on_edge_enable && sd_fall) wfall_r <= 1'b1;
      else if (wue_clr || !wake_on_edge_enable) wfall_r <= 1'b0;
    end
  end

  wake_irq_a: assert property (a_mode && wake_on_edge_enable && sd_fall |=> wake_r && rx_pend) else $error("wake not flagged"); // R2
  brk_rx_a: assert property (a_done && a_char == 9'h000 && !sd_s_r && !ovr_r && !full |=> top[9] && rx_pend)
    else $error("break not reported"); // R1

  // Transmit holding register; a write in the load cycle wins
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_r <= REG_RST;
      hold_full_r <= 1'b0;
    end else if (wr && (i_paddr == TXH_ADDR)) begin
      hold_r <= i_pwdata[7:0];
      hold_full_r <= 1'b1;
    end else if (tx_load) begin
      hold_full_r <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      txc_r <= REG_RST;
      dvl_r <= REG_RST;
      dvh_r <= REG_RST;
    end else if (wr && (i_paddr == TXC_ADDR)) begin
      txc_r <= i_pwdata[7:0] & TXC_WMASK;
    end else if (wr && (i_paddr == DVL_ADDR)) begin
      dvl_r <= i_pwdata[7:0];
    end else if (wr && (i_paddr == DVH_ADDR)) begin
      dvh_r <= i_pwdata[7:0];
    end
  end

  // Software write beats the self-clear of single receive
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rsc_r <= REG_RST;
    end else if (wr && (i_paddr == RSC_ADDR)) begin
      rsc_r <= i_pwdata[7:0] & RSC_WMASK;
    end else if (m_mode && s_rx_done) begin
      // R10 R12 single receive self-clears
      rsc_r[RSC_SINGLE] <= 1'b0;
    end
  end

  single_clr_a: assert property (m_mode && s_rx_done && single_receive_enable && !wr |=> !single_receive_enable)
    else $error("single receive not cleared"); // R10
  cont_go_a: assert property (m_mode && s_rx_done && single_receive_enable && continuous_receive_enable && !wr && !ovr_set |=> m_rx_act ##1 st_r == S_LEAD)
    else $error("continuous receive stopped"); // R12

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bdc_r <= REG_RST;
    end else if (wr && (i_paddr == BDC_ADDR)) begin
      bdc_r <= i_pwdata[7:0] & BDC_WMASK;
    end else if (wue_clr) begin
      bdc_r[BDC_WAKE] <= 1'b0;
    end
  end

  // Read mux
  always_comb begin
    hit = 1'b1;
    rd_val = 8'h00;
    if (i_paddr == TXC_ADDR) begin
      rd_val = {txc_r[7:2], ~sh_busy_r, txc_r[0]};
    end else if (i_paddr == RSC_ADDR) begin
      // R19 ninth bit of the oldest entry
      rd_val = {rsc_r[7:3], top[9], ovr_r, top[8]};
    end else if (i_paddr == BDC_ADDR) begin
      rd_val = {1'b0, a_st_r == A_IDLE, 1'b0, bdc_r[4:0]};
    end else if (i_paddr == DVL_ADDR) begin
      rd_val = dvl_r;
    end else if (i_paddr == DVH_ADDR) begin
      rd_val = dvh_r;
    end else if (i_paddr == TXH_ADDR) begin
      rd_val = 8'h00;
    end else if (i_paddr == RXD_ADDR) begin
      rd_val = top[7:0];
    end else if (i_paddr == STS_ADDR) begin
      rd_val = {6'h00, rx_pend, ~hold_full_r};
    end else begin
      hit = 1'b0;
    end
  end

  // APB answer registered in setup, so every access has no wait state
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup;
      o_prdata <= (setup && !i_pwrite) ? {24'h000000, rd_val} : 32'h00000000;
      o_pslverr <= setup && !hit;
    end
  end

  // Main scenarios
  m_tx_c: cover property (m_mode && sh_busy_r && s_done);
  m_rx_c: cover property (m_mode && push_ok);
  ovr_c: cover property (ovr_set);
  brk_c: cover property (a_done && a_char == 9'h000 && !sd_s_r);
endmodule
`default_nettype wire

// File: test/remote_peer.sv
// Far-end serial peer: slave shifter, link master and async line driver
`timescale 1ns/1ps
`default_nettype none
module remote_peer (
  // Line levels
  input wire logic i_sck,
  input wire logic i_sdat,
  input wire logic i_pol,
  // Own drivers, enable low
  output var logic o_sck,
  output var logic o_sck_oe_n,
  output var logic o_sdat,
  output var logic o_sdat_oe_n
);
  logic [8:0] tx_v = 9'h000;
  logic [8:0] rx_v = 9'h000;
  logic [3:0] nbits = 4'h8;
  logic [3:0] idx = 4'h0;
  int edges = 0;
  event got;
  // Drivers start released, lines rest on their pull-ups
  initial begin
    o_sck = 1'b1;
    o_sck_oe_n = 1'b1;
    o_sdat = 1'b1;
    o_sdat_oe_n = 1'b1;
  end
  // Leading edge puts a bit out, trailing edge takes one in, LSB first
  always @(i_sck) begin
    if (i_sck === ~i_pol) begin
      edges = edges + 1;
      o_sdat = tx_v[idx];
    end else if (i_sck === i_pol) begin
      rx_v[idx] = i_sdat;
      idx = idx + 4'h1;
      if (idx == nbits) begin
        idx = 4'h0;
        -> got;
      end
    end
  end
  // Fresh character; the data driver is only enabled when we talk
  task automatic start(input logic [8:0] v, input logic [3:0] n, input logic talk);
    tx_v = v;
    rx_v = 9'h000;
    nbits = n;
    idx = 4'h0;
    edges = 0;
    o_sdat = v[0];
    o_sdat_oe_n = ~talk;
  endtask
  task automatic clock_out(input logic [8:0] v, input logic [3:0] n, input logic talk);
    o_sck = i_pol;
    o_sck_oe_n = 1'b0;
    #100;
    start(v, n, talk);
    repeat (n) begin
      #62.5 o_sck = ~i_pol;
      #62.5 o_sck = i_pol;
    end
    #100;
  endtask
  // Async frame at 160 ns a bit (divisor zero); stop level is chosen
  task automatic async_send(input logic [7:0] v, input logic stop);
    logic [9:0] f;
    f = {stop, v, 1'b0};
    o_sdat_oe_n = 1'b0;
    for (int i = 0; i < 10; i++) begin
      o_sdat = f[i];
      #160;
    end
    o_sdat_oe_n = 1'b1;
    #480;
  endtask
endmodule
`default_nettype wire

// File: test/sync_serial_port_tb.sv
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_tb
  import sync_serial_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pol = 1'b0;
  logic d_sck, d_sck_oe_n, d_sdat, d_sdat_oe_n;
  logic p_sck, p_sck_oe_n, p_sdat, p_sdat_oe_n;
  wire logic sck_line;
  wire logic sdat_line;
  logic [32:0] rd_got;
  logic [32:0] exp_rd[$];
  logic [8:0] exp_ln[$];
  logic [31:0] lfsr = 32'hA96C9AE4;
  logic [8:0] v;
  int e0;
  int miscompares = 0;
  int num_checks = 0;
  event rd_ev;
  // 100 MHz system clock
  always #5 clk = ~clk;
  // Pull-ups on both lines; an enabled driver wins
  assign sck_line = !d_sck_oe_n ? d_sck : (!p_sck_oe_n ? p_sck : 1'b1);
  assign sdat_line = !d_sdat_oe_n ? d_sdat : (!p_sdat_oe_n ? p_sdat : 1'b1);
  sync_serial_port sync_serial_port_i (.i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_sck(sck_line), .o_sck(d_sck), .o_sck_oe_n(d_sck_oe_n), .i_sdat(sdat_line),
    .o_sdat(d_sdat), .o_sdat_oe_n(d_sdat_oe_n));
  remote_peer remote_peer_i (.i_sck(sck_line), .i_sdat(sdat_line), .i_pol(pol), .o_sck(p_sck),
    .o_sck_oe_n(p_sck_oe_n), .o_sdat(p_sdat), .o_sdat_oe_n(p_sdat_oe_n));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer; pready is awaited, never assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_got = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 8'h00);
    -> rd_ev;
  endtask
  task automatic wait_bit(input logic [7:0] a, input int b);
    do apb(1'b0, a, 8'h00); while (rd_got[b] !== 1'b1);
  endtask
  task automatic end_sim;
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Results are matched against the oldest note when they appear
  always @(rd_ev) chk("read", exp_rd.pop_front(), rd_got);
  always @(remote_peer_i.got) begin
    if (exp_ln.size() > 0) chk("line char", 33'(exp_ln.pop_front()), 33'(remote_peer_i.rx_v));
  end
  // Cut a hang short; the run needs far less
  initial begin
    #500000;
    miscompares++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(RSC_ADDR, 33'h0);
    rd(STS_ADDR, 33'h1);
    rd(TXC_ADDR, 33'h2);
    rd(8'h20, {1'b1, 32'h0});
    wr(TXC_ADDR, 8'hFF);
    rd(TXC_ADDR, 33'hF7);
    wr(DVL_ADDR, 8'h03);
    for (int p = 1; p >= 0; p--) begin
      wr(BDC_ADDR, {3'h0, p[0], 4'h0});
      pol <= p[0];
      // Second pass moves nine-bit characters with the ninth bit set
      wr(TXC_ADDR, p[0] ? 8'hB0 : 8'hF1);
      wr(RSC_ADDR, 8'h80);
      remote_peer_i.start(9'h000, p[0] ? 4'h8 : 4'h9, 1'b0);
      lfsr = nxt(lfsr);
      exp_ln.push_back({~p[0], lfsr[7:0]});
      exp_ln.push_back({~p[0], lfsr[15:8]});
      wr(TXH_ADDR, lfsr[7:0]);
      wr(TXH_ADDR, lfsr[15:8]);
      wait (exp_ln.size() == 0);
      repeat (20) @(posedge clk);
      chk("clock edges", p[0] ? 33'd16 : 33'd18, 33'(remote_peer_i.edges));
      chk("idle clock", 33'(p[0]), 33'(d_sck));
      chk("clock driver", 33'h0, 33'(d_sck_oe_n));
    end
    for (int k = 0; k < 2; k++) begin
      lfsr = nxt(lfsr);
      v = lfsr[8:0];
      wr(RSC_ADDR, k[0] ? 8'hE0 : 8'hA0);
      // Peer talks only once the port has let go of the data pin
      @(posedge clk);
      remote_peer_i.start(v, k[0] ? 4'h9 : 4'h8, 1'b1);
      chk("data driver", 33'h1, 33'(d_sdat_oe_n));
      wait_bit(STS_ADDR, STS_RXP);
      rd(RSC_ADDR, {25'h0, 1'b1, k[0], 5'h00, k[0] & v[8]});
      rd(RXD_ADDR, {25'h0, v[7:0]});
      rd(STS_ADDR, 33'h1);
    end
    remote_peer_i.start(v, 4'h8, 1'b1);
    wr(RSC_ADDR, 8'h90);
    wait_bit(RSC_ADDR, 1);
    repeat (100) @(posedge clk);
    chk("clock edges", 33'd24, 33'(remote_peer_i.edges));
    rd(RSC_ADDR, 33'h92);
    rd(RXD_ADDR, {25'h0, v[7:0]});
    rd(RXD_ADDR, {25'h0, v[7:0]});
    rd(RSC_ADDR, 33'h92);
    wr(RSC_ADDR, 8'h80);
    rd(RSC_ADDR, 33'h80);
    // Three single receives with nothing read: the third overruns, a read clears it
    remote_peer_i.start(v, 4'h8, 1'b1);
    for (int k = 0; k < 3; k++) begin
      wr(RSC_ADDR, 8'hA0);
      repeat (100) @(posedge clk);
    end
    rd(RSC_ADDR, 33'h82);
    rd(RXD_ADDR, {25'h0, v[7:0]});
    rd(RSC_ADDR, 33'h80);
    rd(RXD_ADDR, {25'h0, v[7:0]});
    remote_peer_i.start(v, 4'h8, 1'b1);
    wr(RSC_ADDR, 8'hB0);
    wait_bit(STS_ADDR, STS_RXP);
    rd(RSC_ADDR, 33'h90);
    @(remote_peer_i.edges);
    @(posedge clk);
    wr(RSC_ADDR, 8'h80);
    @(posedge clk);
    e0 = remote_peer_i.edges;
    chk("idle clock", 33'h0, 33'(d_sck));
    repeat (40) @(posedge clk);
    chk("clock edges", 33'(e0), 33'(remote_peer_i.edges));
    wr(RSC_ADDR, 8'h00);
    // Slave runs idle high so the released clock line already rests at idle
    wr(BDC_ADDR, 8'h10);
    pol <= 1'b1;
    wr(TXC_ADDR, 8'h10);
    wr(RSC_ADDR, 8'h90);
    lfsr = nxt(lfsr);
    v = lfsr[8:0];
    remote_peer_i.clock_out(v, 4'h8, 1'b1);
    @(posedge clk);
    chk("clock driver", 33'h1, 33'(d_sck_oe_n));
    rd(STS_ADDR, 33'h3);
    rd(RXD_ADDR, {25'h0, v[7:0]});
    wr(RSC_ADDR, 8'h80);
    wr(TXC_ADDR, 8'h30);
    exp_ln.push_back({1'b0, v[7:0]});
    wr(TXH_ADDR, v[7:0]);
    remote_peer_i.clock_out(9'h000, 4'h8, 1'b0);
    @(posedge clk);
    wr(RSC_ADDR, 8'h00);
    wr(TXC_ADDR, 8'h00);
    wr(DVL_ADDR, 8'h00);
    wr(RSC_ADDR, 8'h90);
    remote_peer_i.async_send(8'h00, 1'b0);
    @(posedge clk);
    rd(STS_ADDR, 33'h3);
    rd(RSC_ADDR, 33'h94);
    rd(RXD_ADDR, 33'h0);
    wr(BDC_ADDR, 8'h02);
    remote_peer_i.async_send(8'h00, 1'b0);
    @(posedge clk);
    rd(BDC_ADDR, 33'h40);
    rd(STS_ADDR, 33'h3);
    apb(1'b0, RXD_ADDR, 8'h00);
    lfsr = nxt(lfsr);
    remote_peer_i.async_send(lfsr[7:0], 1'b1);
    @(posedge clk);
    rd(STS_ADDR, 33'h3);
    rd(RXD_ADDR, {25'h0, lfsr[7:0]});
    chk("line left", 33'h0, 33'(exp_ln.size()));
    end_sim();
  end
endmodule
`default_nettype wire
